// file: verilog/poc_params.svh
// Register map, field positions, reset values and counts of the offset calibration block
`ifndef POC_PARAMS_SVH
`define POC_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define POC_ADDR_OFS_MAG  8'hc0
`define POC_ADDR_OFS_SIGN 8'hc1
`define POC_ADDR_CAL_CTRL 8'hd7
`define POC_ADDR_CAL_CFG  8'hd9
`define POC_ADDR_CAL_STAT 8'hdc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POC_CTRL_HW_AVG   7
`define POC_CTRL_ELEC     5
`define POC_CTRL_WAIT     4
`define POC_CTRL_START    0
`define POC_CFG_TGT_HI    7
`define POC_CFG_TGT_LO    5
`define POC_CFG_AUTO_DEC  3
`define POC_CFG_AVG_HI    2
`define POC_CFG_AVG_LO    0
`define POC_STAT_DEC      2
`define POC_STAT_FIN      0
`define POC_SIGN_BIT      0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define POC_MAG_RST       8'h00
`define POC_CTRL_RST      8'h00
`define POC_CFG_RST       8'h50
`define POC_STAT_RST      8'h00
`define POC_TGT_BASE      11'h004
`define POC_SEARCH_MSB    4'h8

`endif

// file: verilog/poc_pkg.sv
// Types shared by the offset calibration block
package poc_pkg;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } poc_reg_req_t;

   typedef struct packed {
      logic       sign;
      logic [7:0] mag;
   } poc_offset_t;

   // ----------------------------------------
   // State machines
   // ----------------------------------------
   typedef enum logic [1:0] {CS_IDLE, CS_LAUNCH, CS_MEAS, CS_DONE} poc_cal_state_t;
   typedef enum logic [1:0] {SA_IDLE, SA_SAMPLE, SA_WAIT} poc_sa_state_t;

endpackage

// file: verilog/poc_sample_avg.sv
// Hardware sample averager: one burst request per sample, optional wait between samples
`timescale 1ns/1ps
`include "poc_params.svh"

module poc_sample_avg #(
   parameter int DATA_W = 10
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              start,
   input  wire logic [2:0]        code,
   input  wire logic              wait_en,
   input  wire logic              adc_valid,
   input  wire logic [DATA_W-1:0] adc_data,
   input  wire logic              wait_done,
   output logic                   sample_req,
   output logic                   wait_req,
   output logic                   avg_valid,
   output logic [DATA_W-1:0]      avg_data
);
   import poc_pkg::*;

   poc_sa_state_t      state_r;
   logic [7:0]         cnt_r;
   logic [2:0]         code_r;
   logic               wait_r;
   logic [DATA_W+6:0]  acc_r;
   logic [DATA_W+6:0]  acc_nxt;
   logic [7:0]         last;

   assign acc_nxt = acc_r + {7'h00, adc_data};
   assign last    = 8'((9'h001 << code_r) - 9'h001);

   // ----------------------------------------
   // Sample sequencing and accumulation
   // ----------------------------------------
   // A new start restarts at once; a half-collected average is dropped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r    <= SA_IDLE;
         cnt_r      <= 8'h00;
         code_r     <= 3'h0;
         wait_r     <= 1'b0;
         acc_r      <= '0;
         sample_req <= 1'b0;
         wait_req   <= 1'b0;
         avg_valid  <= 1'b0;
         avg_data   <= '0;
      end else begin
         sample_req <= 1'b0;
         wait_req   <= 1'b0;
         avg_valid  <= 1'b0;
         if (start) begin
            state_r    <= SA_SAMPLE;
            cnt_r      <= 8'h00;
            code_r     <= code;
            wait_r     <= wait_en;
            acc_r      <= '0;
            sample_req <= 1'b1; // RL17
         end else begin
            case (state_r)
               SA_SAMPLE: begin
                  if (adc_valid) begin
                     if (cnt_r == last) begin
                        avg_valid <= 1'b1;
                        avg_data  <= DATA_W'(acc_nxt >> code_r);
                        state_r   <= SA_IDLE;
                     end else begin
                        acc_r <= acc_nxt;
                        cnt_r <= cnt_r + 8'h01;
                        if (wait_r) begin
                           wait_req <= 1'b1; // RL8
                           state_r  <= SA_WAIT;
                        end else begin
                           sample_req <= 1'b1; // RL17
                        end
                     end
                  end
               end
               SA_WAIT: begin
                  if (wait_done) begin
                     sample_req <= 1'b1; // RL17
                     state_r    <= SA_SAMPLE;
                  end
               end
               default: state_r <= SA_IDLE;
            endcase
         end
      end
   end

endmodule

// file: verilog/poc_calibration_control.sv
// Proximity crosstalk offset, binary-search calibration and hardware averaging control
//
// Function
// RL1: Offset magnitude register, eight bits read/write, resets to zero.
// RL2: Sign of the offset lives in bit 0 of the sign register.
// RL3: Signed offset up to 255 either way corrects the proximity result.
// RL4: Host writes reserved bits only with their default values.
// RL5: Control bit 7 enables hardware averaging during calibration.
// RL6: Control bit 5 picks electrical-only or combined calibration.
// RL7: Electrical-only calibration disconnects the photodiode; otherwise identical procedure.
// RL8: Control bit 4 inserts the sample wait between calibration samples.
// RL9: Writing one to control bit 0 starts calibration.
// RL10: Binary search drives the result as close as possible to target.
// RL11: Calibration start is accepted at any time.
// RL12: Finished calibration sets the done flag.
// RL13: Finished calibration loads magnitude and sign into the offset registers.
// RL14: Config bits 7:5 pick target 3,7,15,...,511; reset code 2.
// RL15: With config bit 3 set, a zero result decrements the magnitude.
// RL16: Config bits 2:0 set averaged samples: off, 2 up to 128.
// RL17: Each converter sample transmits the programmed emitter pulse burst.
// RL18: Average goes to the result or to the moving-average filter.
// RL19: Status finished bit mirrors the done flag and clears with it.
// RL20: Decrement sets status bit 2; cleared by writing one or disabling.
// RL21: Calibration interrupt enable gates done onto the interrupt request.
// RL22: Filter select 00 off, 01 two, 10 four, 11 eight values.
// RL23: Sign one subtracts the magnitude, sign zero adds it.
// RL24: Start bit clears itself when calibration completes.
`timescale 1ns/1ps
`include "poc_params.svh"

module poc_calibration_control #(
   parameter int DATA_W = 10
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  poc_pkg::poc_reg_req_t  reg_req,
   output logic [7:0]             reg_rdata,
   input  wire logic              prox_cycle_go,
   input  wire logic [1:0]        moving_avg_sel,
   input  wire logic              cal_irq_en,
   input  wire logic              cal_done_clr,
   input  wire logic              adc_valid,
   input  wire logic [DATA_W-1:0] adc_data,
   input  wire logic              wait_done,
   output logic                   emit_burst_go,
   output logic                   wait_go,
   output logic                   pd_disconnect,
   output logic [DATA_W-1:0]      prox_result,
   output logic                   result_valid,
   output logic                   filter_valid,
   output logic                   cal_done_flag,
   output logic                   cal_irq,
   output logic                   cal_busy
);
   import poc_pkg::*;

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   // The largest search target, 511, must fit in the result
   if (DATA_W < 10 || DATA_W > 16) begin : g_bad_width
      $error("poc_calibration_control: DATA_W must lie between 10 and 16");
   end

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [DATA_W-1:0] apply_ofs(input logic [DATA_W-1:0] raw,
                                                   input poc_offset_t       o);
      logic [DATA_W:0]   sum;
      logic [DATA_W-1:0] mag_w;
      mag_w = DATA_W'(o.mag);
      sum   = {1'b0, raw} + {1'b0, mag_w};
      if (o.sign) begin
         apply_ofs = (raw < mag_w) ? '0 : raw - mag_w; // RL23
      end else begin
         apply_ofs = sum[DATA_W] ? '1 : sum[DATA_W-1:0]; // RL23
      end
   endfunction

   // Search code 0..511 stands for offset code-256, clamped to -255
   function automatic poc_offset_t code_to_ofs(input logic [8:0] c);
      poc_offset_t o;
      o = '0;
      if (c[8]) begin
         o.sign = 1'b0;
         o.mag  = c[7:0];
      end else begin
         o.sign = 1'b1;
         o.mag  = (c == 9'h000) ? 8'hff : 8'(9'h100 - c);
      end
      code_to_ofs = o;
   endfunction

   function automatic logic [DATA_W-1:0] target_of(input logic [2:0] c);
      target_of = DATA_W'((`POC_TGT_BASE << c) - 11'h001); // RL14
   endfunction

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0]     ofs_mag_r;
   logic           ofs_sign_r;
   logic           hw_avg_r;
   logic           elec_r;
   logic           wait_apply_r;
   logic           start_r;
   logic [2:0]     tgt_sel_r;
   logic           auto_dec_en_r;
   logic [2:0]     avg_cnt_r;
   logic           dec_flag_r;

   poc_cal_state_t cal_state_r;
   logic [8:0]     code_r;
   logic [8:0]     trial_r;
   logic [3:0]     bit_r;

   logic           wr_mag;
   logic           wr_sign;
   logic           wr_ctrl;
   logic           wr_cfg;
   logic           wr_stat;
   logic           cal_go;
   logic           cal_on;
   logic           norm_go;
   logic           eng_start;
   logic [2:0]     eng_code;
   logic           eng_wait;
   logic           avg_valid;
   logic [DATA_W-1:0] avg_data;
   logic [DATA_W-1:0] norm_res;
   logic [DATA_W-1:0] trial_res;
   logic           norm_done;
   logic           auto_dec_ev;
   poc_offset_t    fin_ofs;
   poc_offset_t    cur_ofs;

   assign wr_mag  = reg_req.wr && reg_req.addr == `POC_ADDR_OFS_MAG;
   assign wr_sign = reg_req.wr && reg_req.addr == `POC_ADDR_OFS_SIGN;
   assign wr_ctrl = reg_req.wr && reg_req.addr == `POC_ADDR_CAL_CTRL;
   assign wr_cfg  = reg_req.wr && reg_req.addr == `POC_ADDR_CAL_CFG;
   assign wr_stat = reg_req.wr && reg_req.addr == `POC_ADDR_CAL_STAT;

   assign cal_go   = wr_ctrl && reg_req.wdata[`POC_CTRL_START]; // RL9 RL11
   assign cal_on   = cal_state_r != CS_IDLE;
   assign norm_go  = prox_cycle_go && !cal_on && !cal_go;
   assign cur_ofs  = '{sign: ofs_sign_r, mag: ofs_mag_r};
   assign fin_ofs  = code_to_ofs(code_r);
   assign norm_res = apply_ofs(avg_data, cur_ofs); // RL3
   assign trial_res = apply_ofs(avg_data, code_to_ofs(trial_r));
   assign norm_done = avg_valid && !cal_on;
   assign auto_dec_ev = norm_done && auto_dec_en_r && norm_res == '0
                        && ofs_mag_r != 8'h00; // RL15

   // ----------------------------------------
   // Averaging engine
   // ----------------------------------------
   // Calibration without averaging takes a single sample per step
   assign eng_start = (cal_state_r == CS_LAUNCH) || norm_go;
   assign eng_code  = cal_on ? (hw_avg_r ? avg_cnt_r : 3'h0) : avg_cnt_r; // RL5 RL16
   assign eng_wait  = cal_on && wait_apply_r; // RL8

   poc_sample_avg #(
      .DATA_W     (DATA_W)
   ) u_avg (
      .clk        (clk),
      .arst_n     (arst_n),
      .start      (eng_start),
      .code       (eng_code),
      .wait_en    (eng_wait),
      .adc_valid  (adc_valid),
      .adc_data   (adc_data),
      .wait_done  (wait_done),
      .sample_req (emit_burst_go),
      .wait_req   (wait_go),
      .avg_valid  (avg_valid),
      .avg_data   (avg_data)
   );

   // ----------------------------------------
   // Calibration search
   // ----------------------------------------
   // Result grows with the search code, so keep each bit that stays at or
   // below the target; nine steps cover the whole signed range
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_state_r <= CS_IDLE;
         code_r      <= 9'h000;
         trial_r     <= 9'h000;
         bit_r       <= 4'h0;
      end else if (cal_go) begin
         cal_state_r <= CS_LAUNCH; // RL11
         code_r      <= 9'h000;
         bit_r       <= `POC_SEARCH_MSB;
      end else begin
         case (cal_state_r)
            CS_LAUNCH: begin
               trial_r     <= code_r | (9'h001 << bit_r); // RL10
               cal_state_r <= CS_MEAS;
            end
            CS_MEAS: begin
               if (avg_valid) begin
                  if (trial_res <= target_of(tgt_sel_r)) begin
                     code_r <= trial_r; // RL10
                  end
                  if (bit_r == 4'h0) begin
                     cal_state_r <= CS_DONE;
                  end else begin
                     bit_r       <= bit_r - 4'h1;
                     cal_state_r <= CS_LAUNCH;
                  end
               end
            end
            CS_DONE:  cal_state_r <= CS_IDLE;
            default:  cal_state_r <= CS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Offset registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ofs_mag_r  <= `POC_MAG_RST; // RL1
         ofs_sign_r <= 1'b0;
      end else if (cal_state_r == CS_DONE) begin
         ofs_mag_r  <= fin_ofs.mag; // RL13
         ofs_sign_r <= fin_ofs.sign; // RL13
      end else begin
         if (auto_dec_ev) begin
            ofs_mag_r <= ofs_mag_r - 8'h01; // RL15
         end else if (wr_mag) begin
            ofs_mag_r <= reg_req.wdata; // RL1
         end
         if (wr_sign) begin
            ofs_sign_r <= reg_req.wdata[`POC_SIGN_BIT]; // RL2
         end
      end
   end

   // ----------------------------------------
   // Control and configuration
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hw_avg_r      <= 1'(`POC_CTRL_RST >> `POC_CTRL_HW_AVG);
         elec_r        <= 1'b0;
         wait_apply_r  <= 1'b0;
         start_r       <= 1'b0;
         tgt_sel_r     <= 3'(`POC_CFG_RST >> `POC_CFG_TGT_LO); // RL14
         auto_dec_en_r <= 1'b0;
         avg_cnt_r     <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            hw_avg_r     <= reg_req.wdata[`POC_CTRL_HW_AVG]; // RL5
            elec_r       <= reg_req.wdata[`POC_CTRL_ELEC]; // RL6
            wait_apply_r <= reg_req.wdata[`POC_CTRL_WAIT]; // RL8
            start_r      <= reg_req.wdata[`POC_CTRL_START]; // RL9
         end else if (cal_state_r == CS_DONE) begin
            start_r <= 1'b0; // RL24
         end
         if (wr_cfg) begin
            tgt_sel_r     <= reg_req.wdata[`POC_CFG_TGT_HI:`POC_CFG_TGT_LO]; // RL14
            auto_dec_en_r <= reg_req.wdata[`POC_CFG_AUTO_DEC]; // RL15
            avg_cnt_r     <= reg_req.wdata[`POC_CFG_AVG_HI:`POC_CFG_AVG_LO]; // RL16
         end
      end
   end

   // ----------------------------------------
   // Flags and interrupt request
   // ----------------------------------------
   // A set in the same cycle as a clear wins, so no completion is lost
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_done_flag <= 1'b0;
         dec_flag_r    <= 1'b0;
         cal_irq       <= 1'b0;
      end else begin
         if (cal_state_r == CS_DONE) begin
            cal_done_flag <= 1'b1; // RL12
         end else if (cal_done_clr) begin
            cal_done_flag <= 1'b0; // RL19
         end
         if (auto_dec_ev) begin
            dec_flag_r <= 1'b1; // RL20
         end else if (!auto_dec_en_r) begin
            dec_flag_r <= 1'b0; // RL20
         end else if (wr_stat && reg_req.wdata[`POC_STAT_DEC]) begin
            dec_flag_r <= 1'b0; // RL20
         end
         cal_irq <= cal_done_flag && cal_irq_en; // RL21
      end
   end

   // ----------------------------------------
   // Result hand-off and front-end control
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prox_result   <= '0;
         result_valid  <= 1'b0;
         filter_valid  <= 1'b0;
         pd_disconnect <= 1'b0;
         cal_busy      <= 1'b0;
      end else begin
         result_valid  <= norm_done && moving_avg_sel == 2'b00; // RL18 RL22
         filter_valid  <= norm_done && moving_avg_sel != 2'b00; // RL18 RL22
         if (norm_done) begin
            prox_result <= norm_res; // RL3
         end
         pd_disconnect <= cal_on && elec_r; // RL7
         cal_busy      <= cal_on;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   // Reserved bits read back as their defaults
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         if (reg_req.addr == `POC_ADDR_OFS_MAG) begin
            reg_rdata <= ofs_mag_r;
         end else if (reg_req.addr == `POC_ADDR_OFS_SIGN) begin
            reg_rdata <= {7'h00, ofs_sign_r};
         end else if (reg_req.addr == `POC_ADDR_CAL_CTRL) begin
            reg_rdata <= {hw_avg_r, 1'b0, elec_r, wait_apply_r, 3'h0, start_r};
         end else if (reg_req.addr == `POC_ADDR_CAL_CFG) begin
            reg_rdata <= {tgt_sel_r, 1'b1, auto_dec_en_r, avg_cnt_r};
         end else if (reg_req.addr == `POC_ADDR_CAL_STAT) begin
            reg_rdata <= {5'h00, dec_flag_r, 1'b0, cal_done_flag}; // RL19
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_done_sets_flag: assert property ( // RL12
      cal_state_r == CS_DONE |=> cal_done_flag && (!start_r || $past(wr_ctrl)))
      else $error("done flag or start bit wrong after calibration");

   a_done_loads_ofs: assert property ( // RL13
      cal_state_r == CS_DONE |=> {ofs_sign_r, ofs_mag_r} == $past(fin_ofs))
      else $error("offset registers not loaded with search result");

   a_search_steps: assert property ( // RL10
      cal_state_r == CS_MEAS && avg_valid && bit_r == 4'h0 && !cal_go
      |=> cal_state_r == CS_DONE ##1 cal_state_r == ($past(cal_go) ? CS_LAUNCH : CS_IDLE))
      else $error("search did not end after the last bit");

   a_pd_disconnect: assert property ( // RL7
      pd_disconnect |-> $past(cal_on && elec_r))
      else $error("photodiode disconnected outside electrical calibration");

   a_irq_gating: assert property ( // RL21
      cal_irq |-> $past(cal_done_flag) && $past(cal_irq_en))
      else $error("calibration interrupt request not gated by enable");

   a_dec_mag: assert property ( // RL15
      auto_dec_ev |=> ofs_mag_r == $past(ofs_mag_r) - 8'h01 && dec_flag_r)
      else $error("automatic decrement missing");

   a_dec_flag_off: assert property ( // RL20
      !auto_dec_en_r |=> !dec_flag_r)
      else $error("decrement flag survives disabled adjustment");

   a_result_route: assert property ( // RL18
      norm_done |=> (result_valid != filter_valid)
                    && result_valid == ($past(moving_avg_sel) == 2'b00))
      else $error("average routed to wrong destination");

endmodule

// file: bench/poc_afe_model.sv
// Behavioural converter and wait timer standing in for the analog front end
`timescale 1ns/1ps
module poc_afe_model #(
   parameter int DATA_W = 10
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              burst_go,
   input  wire logic              wait_go,
   input  wire logic              slow,
   input  wire logic [DATA_W-1:0] level,
   output logic                   adc_valid,
   output logic [DATA_W-1:0]      adc_data,
   output logic                   wait_done
);
   int smp_cnt_r;
   int wt_cnt_r;
   // Data toggles outside valid so a stale sample never looks fresh
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         smp_cnt_r <= 0;
         adc_valid <= 1'b0;
         adc_data  <= '1;
      end else begin
         smp_cnt_r <= burst_go ? (slow ? 6 : 2) : (smp_cnt_r > 0 ? smp_cnt_r - 1 : 0);
         adc_valid <= (smp_cnt_r == 1);
         adc_data  <= (smp_cnt_r == 1) ? level : ~adc_data;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wt_cnt_r  <= 0;
         wait_done <= 1'b0;
      end else begin
         wt_cnt_r  <= wait_go ? (slow ? 4 : 1) : (wt_cnt_r > 0 ? wt_cnt_r - 1 : 0);
         wait_done <= (wt_cnt_r == 1);
      end
   end
endmodule

// file: bench/poc_calibration_control_tb_top.sv
// Self-checking bench for the offset calibration block
`timescale 1ns/1ps
module poc_calibration_control_tb_top;
   import poc_pkg::*;
   logic clk = 0, arst_n = 0, go = 0, irq_en = 0, clr = 0, slow = 0;
   logic [1:0] msel = 0;
   logic [9:0] lvl = 0, adc_d, res;
   logic adc_v, wdone, burst, wgo, pd, rv, fv, done, irq, busy;
   logic [7:0] rdata;
   poc_reg_req_t req = '0;
   int bad_count = 0, compares = 0, nb = 0, nw = 0, nb0 = 0, nw0 = 0;
   integer seed = 44590;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (burst) nb <= nb + 1;
      if (wgo) nw <= nw + 1;
   end
   poc_calibration_control dut (.clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
      .prox_cycle_go(go), .moving_avg_sel(msel), .cal_irq_en(irq_en), .cal_done_clr(clr),
      .adc_valid(adc_v), .adc_data(adc_d), .wait_done(wdone), .emit_burst_go(burst),
      .wait_go(wgo), .pd_disconnect(pd), .prox_result(res), .result_valid(rv),
      .filter_valid(fv), .cal_done_flag(done), .cal_irq(irq), .cal_busy(busy));
   poc_afe_model afe (.clk(clk), .arst_n(arst_n), .burst_go(burst), .wait_go(wgo),
      .slow(slow), .level(lvl), .adc_valid(adc_v), .adc_data(adc_d), .wait_done(wdone));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task acc(logic w, logic [7:0] a, logic [7:0] d);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
      @(negedge clk);
   endtask
   task rchk(string nm, logic [7:0] a, logic [7:0] exp);
      acc(0, a, 8'h00);
      chk(nm, 16'(rdata), 16'(exp));
   endtask
   // Bounded wait for done (cal) or a result strobe
   task wt(bit cal);
      int i;
      for (i = 0; i < 20000; i++) begin
         @(negedge clk);
         if (cal ? done : (rv | fv)) break;
      end
      if (i == 20000) begin
         bad_count++;
         wrap_up;
      end
   endtask
   function automatic int corr(int x, bit s, int m);
      int v;
      v = s ? x - m : x + m;
      return v < 0 ? 0 : (v > 1023 ? 1023 : v);
   endfunction
   task pulse_go;
      nb0 = nb;
      go = 1;
      @(negedge clk);
      go = 0;
      wt(0);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int t, d, n, tg;
      logic [7:0] ctl;
      repeat (6) @(negedge clk);
      arst_n = 1;
      @(negedge clk);
      rchk("mag", 8'hc0, 8'h00);
      rchk("sign", 8'hc1, 8'h00);
      rchk("ctrl", 8'hd7, 8'h00);
      rchk("cfg", 8'hd9, 8'h50);
      rchk("stat", 8'hdc, 8'h00);
      rchk("unmapped", 8'h55, 8'h00);
      for (t = 0; t < 8; t++) begin
         d = $random(seed) & 255;
         acc(1, 8'hc0, d[7:0]);
         rchk("mag rw", 8'hc0, d[7:0]);
         acc(1, 8'hc1, {7'h0, t[0]});
         rchk("sign rw", 8'hc1, {7'h0, t[0]});
         acc(1, 8'hd9, {5'h0a, t[2:0]});
         lvl = 10'($random(seed));
         msel = t[1:0];
         pulse_go;
         chk("result", 16'(res), 16'(corr(lvl, t[0], d)));
         chk("to filter", 16'(fv), 16'(msel != 0));
         chk("direct", 16'(rv), 16'(msel == 0));
         chk("bursts", 16'(nb - nb0), 16'(1 << t));
      end
      // Auto decrement: W1C clear, then clear by disabling
      acc(1, 8'hc0, 8'h10);
      acc(1, 8'hc1, 8'h01);
      acc(1, 8'hd9, 8'h58);
      lvl = 10'd5;
      pulse_go;
      rchk("dec mag", 8'hc0, 8'h0f);
      rchk("dec flag", 8'hdc, 8'h04);
      acc(1, 8'hdc, 8'h04);
      rchk("w1c", 8'hdc, 8'h00);
      pulse_go;
      rchk("dec mag2", 8'hc0, 8'h0e);
      rchk("dec flag2", 8'hdc, 8'h04);
      acc(1, 8'hd9, 8'h50);
      rchk("dis clr", 8'hdc, 8'h00);
      // Calibration over every target code and control mix
      for (t = 0; t < 8; t++) begin
         tg = (4 << t) - 1;
         d = 1 + ($random(seed) & 127);
         lvl = 10'(tg > d ? tg - d : tg + d);
         acc(1, 8'hd9, {t[2:0], 3'b100, t[1:0]});
         ctl = {t[0], 1'b0, t[1], t[2], 3'b000, 1'b1};
         slow = t[0];
         irq_en = t[1];
         nb0 = nb;
         nw0 = nw;
         acc(1, 8'hd7, ctl);
         chk("busy", 16'(busy), 16'h1);
         chk("pd", 16'(pd), 16'(t[1]));
         wt(1);
         n = t[0] ? 1 << t[1:0] : 1;
         chk("done", 16'(done), 16'h1);
         chk("cal bursts", 16'(nb - nb0), 16'(9 * n));
         chk("waits", 16'(nw - nw0), 16'(t[2] ? 9 * (n - 1) : 0));
         @(negedge clk);
         chk("irq", 16'(irq), 16'(t[1]));
         chk("pd end", 16'(pd), 16'h0);
         chk("busy end", 16'(busy), 16'h0);
         rchk("cal mag", 8'hc0, 8'(tg > lvl ? tg - lvl : lvl - tg));
         rchk("cal sign", 8'hc1, {7'h0, lvl > tg});
         rchk("start clr", 8'hd7, ctl & 8'hfe);
         rchk("fin copy", 8'hdc, 8'h01);
         clr = 1;
         @(negedge clk);
         clr = 0;
         @(negedge clk);
         rchk("fin clr", 8'hdc, 8'h00);
      end
      wrap_up;
   end
endmodule
